// *** mcs_mem_model.sv ***
// external memory with address latch and internal ram block decode.
// assumes the sequencer's multiplexed address and strobes; 256 bytes mirrored.
`default_nettype none
module mcs_mem_model #(
	parameter logic [15:0] RAM_BASE = 16'h0000
) (
	input wire logic clk,
	input wire logic pulse_first,
	input wire logic pulse_second,
	input wire logic [7:0] mux_addr,
	input wire logic write_strobe_n,
	input wire logic read_level_n,
	output logic [7:0] data_in,
	output logic ram_select_n,
	output logic [15:0] addr,
	output logic [7:0] wr_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] hi = 8'h00;
	logic [7:0] last_d = 8'h00;
	logic lo_ok = 1'b0;
	initial begin
		foreach (mem[k]) mem[k] = 8'hc4;
		mem[0] = 8'h7b;
		mem[1] = 8'h7a;
		mem[2] = 8'h6a;
		mem[3] = 8'h50;
		mem[4] = 8'h62;
		wr_count = 8'h00;
	end
	always @(negedge pulse_first) hi = mux_addr;
	always @(posedge pulse_second) addr = {hi, mux_addr};
	always @(posedge write_strobe_n) wr_count = wr_count + 8'h01;
	always @(posedge clk) begin
		lo_ok <= !pulse_first;
		last_d <= data_in;
	end
	// undriven bus shows a moving pattern, never the last byte
	assign data_in = (!read_level_n && lo_ok) ? mem[mux_addr] : ~last_d;
	assign ram_select_n = !(lo_ok && {hi, mux_addr[7:6]} == RAM_BASE[15:6]
		&& !(read_level_n && write_strobe_n));
endmodule : mcs_mem_model
`default_nettype wire

// *** mcs_pkg.sv ***
// package for the machine-cycle bus sequencer: cycle states, clock-phase indices,
// opcode constants and fixed designator values.
// assumes a single 200 MHz clock domain; the core clock equals the cpu input clock.
`default_nettype none
package mcs_pkg;
	// ==========================================================
	// machine cycle types, encoded as the two state-code lines
	typedef enum logic [1:0] {
		MCS_FETCH = 2'b00,
		MCS_EXEC  = 2'b01,
		MCS_DMA   = 2'b10,
		MCS_IACK  = 2'b11
	} mcs_cycle_t;

	// ==========================================================
	// clock phases within one machine cycle
	localparam int PHASE_W = 3;
	localparam logic [2:0] PHASES_LAST = 3'h7;
	localparam logic [2:0] PH_PULSE_FIRST = 3'h1;
	localparam logic [2:0] PH_ADDR_LOW = 3'h3;
	localparam logic [2:0] PH_WR_START = 3'h4;
	localparam logic [2:0] PH_WR_END = 3'h5;
	localparam logic [2:0] PH_Q_CHANGE = 3'h4;
	localparam logic [2:0] PH_PULSE_SECOND = 3'h6;
	localparam logic [2:0] PH_RAM_SELECT = 3'h7;
	localparam logic [2:0] PH_RAM_DATA = 3'h3;

	// ==========================================================
	// designators and constants
	localparam logic [3:0] REG_DMA = 4'h0;
	localparam logic [3:0] REG_IRQ_PC = 4'h1;
	localparam logic [3:0] REG_IRQ_X = 4'h2;
	localparam logic [3:0] REG_RESET_PC = 4'h0;
	localparam logic [7:0] CNT_UNDERFLOW = 8'h01;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] REG_INC = 16'h0001;
	localparam logic [3:0] OPC_IO_OUT = 4'h6;
	localparam logic [3:0] OPC_SHORT_BR = 4'h3;
	localparam logic [3:0] OPC_MISC = 4'h7;
	localparam logic [3:0] N_SET_Q = 4'hb;
	localparam logic [3:0] N_RESET_Q = 4'ha;
	localparam logic [3:0] N_IO_DIR = 4'h8;
	localparam logic [3:0] N_LOAD_OP = 4'h0;
	localparam logic [3:0] OPC_LOAD = 4'h4;
	localparam logic [3:0] OPC_STORE = 4'h5;
	localparam logic [2:0] IO_IDLE = 3'h0;
endpackage : mcs_pkg
`default_nettype wire

// *** mcs_properties.sv ***
// port checker for the machine-cycle sequencer.
// assumes one clock domain; bound onto every sequencer instance.
`default_nettype none
module mcs_properties (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CLEAR_N,
	input wire logic WAIT_N,
	input wire logic COUNTER_DEC,
	input wire logic TIMING_PULSE_FIRST,
	input wire logic TIMING_PULSE_SECOND,
	input wire logic STATE_CODE_LOW,
	input wire logic STATE_CODE_HIGH,
	input wire logic [7:0] MUX_ADDRESS_LINES,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_LEVEL_N,
	input wire logic [2:0] IO_SELECT_LINES,
	input wire logic Q,
	input wire logic RAM_DATA_DRIVE,
	input wire logic MASTER_IRQ_ENABLE,
	input wire logic [3:0] INSTR_HIGH,
	input wire logic [3:0] OPERAND,
	input wire logic PAUSED
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// helpers
	logic [3:0] quiet;
	logic [1:0] code;
	assign code = {STATE_CODE_HIGH, STATE_CODE_LOW};
	// mode pins pass a synchroniser, so timing checks rest a while after any stop
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			quiet <= 4'hc;
		end else if (!(CLEAR_N && WAIT_N)) begin
			quiet <= 4'hc;
		end else if (quiet != 4'h0) begin
			quiet <= quiet - 4'h1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN || quiet != 4'h0);
	// ==========
	// assertions
	AST_FIRST_PERIOD: assert property (TIMING_PULSE_FIRST |=>
		!TIMING_PULSE_FIRST [*7] ##1 TIMING_PULSE_FIRST) else $error("first pulse period");
	AST_SECOND_AFTER_FIRST: assert property (TIMING_PULSE_FIRST |->
		!TIMING_PULSE_SECOND [*5] ##1 TIMING_PULSE_SECOND) else $error("second pulse place");
	AST_CODE_STEADY: assert property (TIMING_PULSE_FIRST |->
		$stable(code) ##1 $stable(code)) else $error("state code moves at first pulse");
	AST_FETCH_EXEC: assert property (TIMING_PULSE_FIRST && code == mcs_pkg::MCS_FETCH
		|-> ##8 code == mcs_pkg::MCS_EXEC) else $error("fetch not followed by execute");
	AST_IACK_ONE: assert property (TIMING_PULSE_FIRST && code == mcs_pkg::MCS_IACK
		|-> ##8 code != mcs_pkg::MCS_IACK) else $error("ack cycle repeated");
	AST_WR_ADDR: assert property ($fell(WRITE_STROBE_N) |-> $stable(MUX_ADDRESS_LINES)
		##1 !WRITE_STROBE_N && $stable(MUX_ADDRESS_LINES) ##1 WRITE_STROBE_N)
		else $error("write strobe shape");
	AST_WR_CYCLE: assert property (!WRITE_STROBE_N |->
		READ_LEVEL_N && code != mcs_pkg::MCS_FETCH) else $error("write in read");
	AST_IO_LINES: assert property (IO_SELECT_LINES != 3'h0 |->
		code == mcs_pkg::MCS_EXEC && INSTR_HIGH == mcs_pkg::OPC_IO_OUT
		&& IO_SELECT_LINES == OPERAND[2:0]) else $error("io lines");
	AST_Q_PULSES: assert property ((TIMING_PULSE_FIRST || TIMING_PULSE_SECOND)
		&& !COUNTER_DEC && !$past(COUNTER_DEC) |-> $stable(Q)) else $error("q at pulse");
	AST_MIE_DROP: assert property ($fell(MASTER_IRQ_ENABLE) |->
		code == mcs_pkg::MCS_IACK) else $error("enable dropped outside ack");
	AST_RAM_IDLE: assert property (READ_LEVEL_N && WRITE_STROBE_N
		&& $past(READ_LEVEL_N && WRITE_STROBE_N) |-> !RAM_DATA_DRIVE) else $error("ram drive");
	AST_PAUSE_HOLD: assert property (disable iff (!RESETN) PAUSED [*3] |->
		$stable(code) && $stable(MUX_ADDRESS_LINES)) else $error("pause moved");
	cover property (TIMING_PULSE_FIRST && code == mcs_pkg::MCS_IACK);
	cover property (TIMING_PULSE_FIRST && code == mcs_pkg::MCS_DMA);
	cover property ($fell(WRITE_STROBE_N));
	cover property (disable iff (!RESETN) PAUSED);
endmodule : mcs_properties
bind mcs_sequencer mcs_properties u_mcs_properties (.CLK, .RESETN, .CLEAR_N, .WAIT_N,
	.COUNTER_DEC, .TIMING_PULSE_FIRST, .TIMING_PULSE_SECOND, .STATE_CODE_LOW,
	.STATE_CODE_HIGH, .MUX_ADDRESS_LINES, .WRITE_STROBE_N, .READ_LEVEL_N,
	.IO_SELECT_LINES, .Q, .RAM_DATA_DRIVE, .MASTER_IRQ_ENABLE, .INSTR_HIGH, .OPERAND, .PAUSED);
`default_nettype wire

// *** mcs_sequencer.sv ***
// machine-cycle sequencer and external bus interface of an 8-bit register cpu.
// assumes pins arrive asynchronously; memory, address latch and i/o sit outside.
// Overview of operation
// RULE_01: flags sampled at end of fetch
// RULE_02: dma requests sampled at second pulse, non-fetch
// RULE_03: interrupt sampled at second pulse, execute/dma only
// RULE_04: irq saves designators, sets 2/1, disables
// RULE_05: interrupt acknowledge takes one state-3 cycle
// RULE_06: dma uses R0 address, then increments it
// RULE_07: priority dma-in, dma-out, interrupt; irq held
// RULE_08: state codes encode cycle type at first pulse
// RULE_09: one first and one second pulse per cycle
// RULE_10: high address byte, then low after first pulse
// RULE_11: write strobe only after address stable
// RULE_12: read level low in reads; i/o direction
// RULE_13: Q changes between first and second pulse
// RULE_14: toggle Q at counter 01 underflow
// RULE_15: toggle cleared by load, reset, counter branch
// RULE_16: eight clocks per machine cycle
// RULE_17: clear/wait pins select run, pause, reset
// RULE_18: internal ram select window clocks 31..71
// RULE_19: ram select ignored when no access strobe
// RULE_20: ram base address decoded externally
// RULE_21: fetch via R(P), split byte into I and N
// RULE_22: sixteen 16-bit registers, 4-bit designators
// RULE_23: io select lines low unless i/o instruction
// RULE_24: leaving reset starts fetch with R0
`default_nettype none
module mcs_sequencer (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CLEAR_N,
	input wire logic WAIT_N,
	input wire logic [3:0] STATUS_FLAG_IN,
	input wire logic DMA_IN_REQ_N,
	input wire logic DMA_OUT_REQ_N,
	input wire logic IRQ_REQ_N,
	input wire logic INTERNAL_RAM_SELECT_N,
	input wire logic [7:0] DATA_IN,
	input wire logic [7:0] COUNTER_VALUE,
	input wire logic COUNTER_DEC,
	input wire logic COUNTER_RUNNING,
	input wire logic COUNTER_IRQ_LATCH,
	input wire logic TOGGLE_Q_ENABLE_CMD,
	output logic TIMING_PULSE_FIRST,
	output logic TIMING_PULSE_SECOND,
	output logic STATE_CODE_LOW,
	output logic STATE_CODE_HIGH,
	output logic [7:0] MUX_ADDRESS_LINES,
	output logic WRITE_STROBE_N,
	output logic READ_LEVEL_N,
	output logic [2:0] IO_SELECT_LINES,
	output logic Q,
	output logic RAM_DATA_DRIVE,
	output logic MASTER_IRQ_ENABLE,
	output logic [3:0] FLAG_LEVELS,
	output logic [3:0] INSTR_HIGH,
	output logic [3:0] OPERAND,
	output logic [7:0] TEMP_SAVE,
	output logic PAUSED
);
	// ==========================================================
	// pin synchronisers
	logic [8:0] sync_in;
	logic clear_s, wait_s, dmai_s, dmao_s, irq_s, ram_sel_s;
	logic [3:0] flag_s;

	mcs_sync #(.W(9)) u_sync (
		.clk(CLK),
		.resetn(RESETN),
		.d({CLEAR_N, WAIT_N, STATUS_FLAG_IN, DMA_IN_REQ_N, DMA_OUT_REQ_N,
			IRQ_REQ_N}),
		.q(sync_in)
	);
	logic ram_sel_meta;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ram_sel_meta <= 1'b1;
			ram_sel_s <= 1'b1;
		end else begin
			ram_sel_meta <= INTERNAL_RAM_SELECT_N;
			ram_sel_s <= ram_sel_meta;
		end
	end
	assign clear_s = sync_in[8];
	assign wait_s = sync_in[7];
	assign flag_s = sync_in[6:3];
	assign dmai_s = ~sync_in[2];
	assign dmao_s = ~sync_in[1];
	assign irq_s = ~sync_in[0];

	// ==========================================================
	// control mode: both-low is forbidden, treated as reset
	logic cpu_reset, run;
	assign cpu_reset = ~clear_s; // RULE_17
	assign run = clear_s & wait_s; // RULE_17

	// ==========================================================
	// phase counter: eight clocks per cycle; pause holds the phase
	logic [2:0] phase;
	logic cycle_end;
	assign cycle_end = run && phase == mcs_pkg::PHASES_LAST;
	assign PAUSED = clear_s & ~wait_s;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			phase <= '0;
		end else if (cpu_reset) begin
			phase <= '0;
		end else if (run) begin
			phase <= phase + 3'h1; // RULE_16
		end
	end

	// ==========================================================
	// register array and designators
	logic [15:0] regs [16]; // RULE_22
	logic [3:0] p_des, x_des;
	mcs_pkg::mcs_cycle_t cycle;
	logic [3:0] addr_sel;
	logic [15:0] addr;
	logic exec_pending;
	logic dmai_req, dmao_req, irq_req, dma_is_in;

	always_comb begin
		case (cycle)
			mcs_pkg::MCS_FETCH: addr_sel = p_des; // RULE_21
			mcs_pkg::MCS_DMA: addr_sel = mcs_pkg::REG_DMA; // RULE_06
			mcs_pkg::MCS_EXEC: addr_sel = (INSTR_HIGH == mcs_pkg::OPC_LOAD ||
				INSTR_HIGH == mcs_pkg::OPC_STORE) ? OPERAND : x_des;
			default: addr_sel = x_des;
		endcase
	end
	assign addr = regs[addr_sel];

	// increments at cycle end: program counter after fetch, R0 after dma
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_reg
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					regs[gi] <= mcs_pkg::REG_RESET;
				end else if (cpu_reset) begin
					regs[gi] <= mcs_pkg::REG_RESET;
				end else if (cycle_end && addr_sel == 4'(gi) &&
						(cycle == mcs_pkg::MCS_FETCH || cycle == mcs_pkg::MCS_DMA)) begin
					regs[gi] <= regs[gi] + mcs_pkg::REG_INC; // RULE_21 RULE_06
				end
			end
		end
	endgenerate

	// ==========================================================
	// request sampling at the second timing pulse
	logic at_second;
	assign at_second = run && phase == mcs_pkg::PH_PULSE_SECOND;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dmai_req <= 1'b0;
			dmao_req <= 1'b0;
		end else if (cpu_reset || cycle == mcs_pkg::MCS_FETCH) begin
			dmai_req <= 1'b0;
			dmao_req <= 1'b0;
		end else if (at_second) begin
			dmai_req <= dmai_s; // RULE_02
			dmao_req <= dmao_s; // RULE_02
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_req <= 1'b0;
		end else if (cpu_reset) begin
			irq_req <= 1'b0;
		end else if (at_second) begin
			// not latched: only execute and dma cycles see it
			irq_req <= irq_s && (cycle == mcs_pkg::MCS_EXEC ||
				cycle == mcs_pkg::MCS_DMA); // RULE_03
		end
	end

	// ==========================================================
	// cycle sequencing
	logic exec_done;
	assign exec_done = ~exec_pending;
	mcs_pkg::mcs_cycle_t next_cycle;

	always_comb begin
		next_cycle = mcs_pkg::MCS_FETCH;
		case (cycle)
			mcs_pkg::MCS_FETCH: next_cycle = mcs_pkg::MCS_EXEC; // RULE_16
			mcs_pkg::MCS_EXEC, mcs_pkg::MCS_DMA: begin
				if (cycle == mcs_pkg::MCS_EXEC && !exec_done) begin
					next_cycle = mcs_pkg::MCS_EXEC;
				end else if (dmai_req || dmao_req) begin
					next_cycle = mcs_pkg::MCS_DMA; // RULE_07
				end else if (irq_req && MASTER_IRQ_ENABLE) begin
					next_cycle = mcs_pkg::MCS_IACK; // RULE_07
				end else begin
					next_cycle = mcs_pkg::MCS_FETCH;
				end
			end
			mcs_pkg::MCS_IACK: next_cycle = (dmai_req || dmao_req) ?
				mcs_pkg::MCS_DMA : mcs_pkg::MCS_FETCH; // RULE_05
			default: next_cycle = mcs_pkg::MCS_FETCH;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cycle <= mcs_pkg::MCS_FETCH;
		end else if (cpu_reset) begin
			cycle <= mcs_pkg::MCS_FETCH; // RULE_24
		end else if (cycle_end) begin
			cycle <= next_cycle;
		end
	end

	// dma direction fixed when the dma cycle starts; in beats out
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dma_is_in <= 1'b0;
		end else if (cycle_end && next_cycle == mcs_pkg::MCS_DMA) begin
			dma_is_in <= dmai_req; // RULE_07
		end
	end

	// single execute cycle per instruction in this model
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			exec_pending <= 1'b0;
		end else begin
			exec_pending <= 1'b0;
		end
	end

	// ==========================================================
	// fetch: split opcode, sample flags at end of fetch
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			INSTR_HIGH <= '0;
			OPERAND <= '0;
			FLAG_LEVELS <= '0;
		end else if (cycle_end && cycle == mcs_pkg::MCS_FETCH) begin
			INSTR_HIGH <= DATA_IN[7:4]; // RULE_21
			OPERAND <= DATA_IN[3:0]; // RULE_21
			FLAG_LEVELS <= ~flag_s; // RULE_01
		end
	end

	// ==========================================================
	// designators and interrupt acknowledge
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			p_des <= mcs_pkg::REG_RESET_PC;
			x_des <= mcs_pkg::REG_RESET_PC;
			TEMP_SAVE <= '0;
			MASTER_IRQ_ENABLE <= 1'b1;
		end else if (cpu_reset) begin
			p_des <= mcs_pkg::REG_RESET_PC; // RULE_24
			x_des <= mcs_pkg::REG_RESET_PC;
			MASTER_IRQ_ENABLE <= 1'b1;
		end else if (cycle_end && cycle == mcs_pkg::MCS_IACK) begin
			TEMP_SAVE <= {x_des, p_des}; // RULE_04
			x_des <= mcs_pkg::REG_IRQ_X; // RULE_04
			p_des <= mcs_pkg::REG_IRQ_PC; // RULE_04
			MASTER_IRQ_ENABLE <= 1'b0; // RULE_04
		end
	end

	// ==========================================================
	// timing pulses, state code, address multiplex, strobes
	logic is_io, is_write, is_read;
	assign is_io = cycle == mcs_pkg::MCS_EXEC && INSTR_HIGH == mcs_pkg::OPC_IO_OUT &&
		OPERAND[2:0] != mcs_pkg::IO_IDLE;
	assign is_write = (cycle == mcs_pkg::MCS_DMA && dma_is_in) ||
		(cycle == mcs_pkg::MCS_EXEC && INSTR_HIGH == mcs_pkg::OPC_STORE) ||
		(is_io && OPERAND[3]);
	assign is_read = !is_write && cycle != mcs_pkg::MCS_IACK;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			TIMING_PULSE_FIRST <= 1'b0;
			TIMING_PULSE_SECOND <= 1'b0;
			STATE_CODE_LOW <= 1'b0;
			STATE_CODE_HIGH <= 1'b0;
			MUX_ADDRESS_LINES <= '0;
			WRITE_STROBE_N <= 1'b1;
			READ_LEVEL_N <= 1'b1;
			IO_SELECT_LINES <= '0;
		end else begin
			TIMING_PULSE_FIRST <= run && phase == mcs_pkg::PH_PULSE_FIRST; // RULE_09
			TIMING_PULSE_SECOND <= at_second; // RULE_09
			{STATE_CODE_HIGH, STATE_CODE_LOW} <= cycle; // RULE_08
			MUX_ADDRESS_LINES <= (phase < mcs_pkg::PH_ADDR_LOW) ? addr[15:8] :
				addr[7:0]; // RULE_10
			WRITE_STROBE_N <= !(is_write && phase >= mcs_pkg::PH_WR_START &&
				phase <= mcs_pkg::PH_WR_END); // RULE_11
			// during i/o the read level shows transfer direction
			READ_LEVEL_N <= !(is_read && !cpu_reset); // RULE_12
			IO_SELECT_LINES <= is_io ? OPERAND[2:0] : mcs_pkg::IO_IDLE; // RULE_23
		end
	end

	// ==========================================================
	// Q flip-flop
	logic toggle_q;
	logic q_instr;
	assign q_instr = cycle == mcs_pkg::MCS_EXEC && INSTR_HIGH == mcs_pkg::OPC_MISC &&
		(OPERAND == mcs_pkg::N_SET_Q || OPERAND == mcs_pkg::N_RESET_Q);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			toggle_q <= 1'b0;
		end else if (cpu_reset) begin
			toggle_q <= 1'b0; // RULE_15
		end else if (cycle_end && cycle == mcs_pkg::MCS_EXEC &&
				((INSTR_HIGH == mcs_pkg::OPC_MISC && OPERAND == mcs_pkg::N_LOAD_OP &&
				!COUNTER_RUNNING) ||
				(INSTR_HIGH == mcs_pkg::OPC_SHORT_BR && COUNTER_IRQ_LATCH))) begin
			toggle_q <= 1'b0; // RULE_15
		end else if (TOGGLE_Q_ENABLE_CMD) begin
			toggle_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			Q <= 1'b0;
		end else if (cpu_reset) begin
			Q <= 1'b0;
		end else if (q_instr && run && phase == mcs_pkg::PH_Q_CHANGE) begin
			Q <= OPERAND == mcs_pkg::N_SET_Q; // RULE_13
		end else if (toggle_q && COUNTER_DEC && COUNTER_VALUE == mcs_pkg::CNT_UNDERFLOW) begin
			Q <= ~Q; // RULE_14
		end
	end

	// ==========================================================
	// internal ram select; base decode is left to outside logic
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RAM_DATA_DRIVE <= 1'b0;
		end else if (READ_LEVEL_N && WRITE_STROBE_N) begin
			RAM_DATA_DRIVE <= 1'b0; // RULE_19
		end else if (run && phase == mcs_pkg::PH_RAM_SELECT) begin
			RAM_DATA_DRIVE <= 1'b0; // RULE_18
		end else if (run && phase >= mcs_pkg::PH_RAM_DATA) begin
			RAM_DATA_DRIVE <= !ram_sel_s; // RULE_18 RULE_20
		end
	end
endmodule : mcs_sequencer
`default_nettype wire

// *** mcs_sequencer_tb.sv ***
// self-checking bench for the machine-cycle sequencer.
// assumes the memory model answers fetches; inputs change on falling edges.
`default_nettype none
module mcs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] C_FETCH = {6'h0, mcs_pkg::MCS_FETCH};
	localparam logic [7:0] C_EXEC = {6'h0, mcs_pkg::MCS_EXEC};
	localparam logic [7:0] C_DMA = {6'h0, mcs_pkg::MCS_DMA};
	localparam logic [7:0] C_IACK = {6'h0, mcs_pkg::MCS_IACK};
	localparam logic [7:0] PROG [5] = '{8'h7b, 8'h7a, 8'h6a, 8'h50, 8'h62};
	localparam logic [2:0] EXP_IO [5] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h2};
	localparam logic [4:0] EXP_Q = 5'h01;
	localparam logic [4:0] EXP_RD = 5'h0c;
	localparam logic [4:0] EXP_WR = 5'h0c;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic CLEAR_N = 1'b1;
	logic WAIT_N = 1'b1;
	logic [3:0] STATUS_FLAG_IN = 4'hf;
	logic DMA_IN_REQ_N = 1'b1;
	logic DMA_OUT_REQ_N = 1'b1;
	logic IRQ_REQ_N = 1'b1;
	logic [7:0] COUNTER_VALUE = 8'h00;
	logic COUNTER_DEC = 1'b0;
	logic COUNTER_RUNNING = 1'b0;
	logic COUNTER_IRQ_LATCH = 1'b0;
	logic TOGGLE_Q_ENABLE_CMD = 1'b0;
	logic INTERNAL_RAM_SELECT_N, TIMING_PULSE_FIRST, TIMING_PULSE_SECOND, STATE_CODE_LOW;
	logic STATE_CODE_HIGH, WRITE_STROBE_N, READ_LEVEL_N, Q, RAM_DATA_DRIVE, MASTER_IRQ_ENABLE;
	logic PAUSED, q0;
	logic [7:0] DATA_IN, MUX_ADDRESS_LINES, TEMP_SAVE, w, wr_count;
	logic [3:0] FLAG_LEVELS, INSTR_HIGH, OPERAND;
	logic [2:0] IO_SELECT_LINES;
	logic [15:0] mem_addr, a;
	int fail_count = 0;
	int samples_checked = 0;
	int i, n, m;
	mcs_sequencer u_mcs_sequencer (.CLK, .RESETN, .CLEAR_N, .WAIT_N, .STATUS_FLAG_IN,
		.DMA_IN_REQ_N, .DMA_OUT_REQ_N, .IRQ_REQ_N, .INTERNAL_RAM_SELECT_N, .DATA_IN,
		.COUNTER_VALUE, .COUNTER_DEC, .COUNTER_RUNNING, .COUNTER_IRQ_LATCH,
		.TOGGLE_Q_ENABLE_CMD, .TIMING_PULSE_FIRST, .TIMING_PULSE_SECOND, .STATE_CODE_LOW,
		.STATE_CODE_HIGH, .MUX_ADDRESS_LINES, .WRITE_STROBE_N, .READ_LEVEL_N,
		.IO_SELECT_LINES, .Q, .RAM_DATA_DRIVE, .MASTER_IRQ_ENABLE, .FLAG_LEVELS,
		.INSTR_HIGH, .OPERAND, .TEMP_SAVE, .PAUSED);
	mcs_mem_model u_mcs_mem_model (.clk(CLK), .pulse_first(TIMING_PULSE_FIRST),
		.pulse_second(TIMING_PULSE_SECOND), .mux_addr(MUX_ADDRESS_LINES),
		.write_strobe_n(WRITE_STROBE_N), .read_level_n(READ_LEVEL_N), .data_in(DATA_IN),
		.ram_select_n(INTERNAL_RAM_SELECT_N), .addr(mem_addr), .wr_count(wr_count));
	// ==========
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// counts falling edges until the chosen pulse is high; gives up at 64
	task automatic pulse(input logic second, output int cnt);
		cnt = 0;
		do begin
			@(negedge CLK);
			cnt++;
		end while ((second ? TIMING_PULSE_SECOND : TIMING_PULSE_FIRST) !== 1'b1 && cnt < 64);
	endtask : pulse
	task automatic dec_at(input logic [7:0] v);
		COUNTER_VALUE = v;
		COUNTER_DEC = 1'b1;
		@(negedge CLK);
		COUNTER_DEC = 1'b0;
		repeat (3) @(negedge CLK);
	endtask : dec_at
	function automatic logic [7:0] code();
		return {6'h0, STATE_CODE_HIGH, STATE_CODE_LOW};
	endfunction : code
	// ==========
	// clock, watchdog, tests
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		#50000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (16) @(negedge CLK);
		check(WRITE_STROBE_N, 1'b1);
		check(IO_SELECT_LINES, 3'h0);
		RESETN = 1'b1;
		pulse(1'b0, n);
		for (i = 0; i < 5; i++) begin
			STATUS_FLAG_IN = 4'(i);
			check(code(), C_FETCH);
			check(MUX_ADDRESS_LINES, 8'h00);
			pulse(1'b1, m);
			check(READ_LEVEL_N, 1'b0);
			check(RAM_DATA_DRIVE, 1'b1);
			w = wr_count;
			pulse(1'b0, n);
			check(8'(m + n), 8'h08);
			check(code(), C_EXEC);
			check({INSTR_HIGH, OPERAND}, PROG[i]);
			check({4'h0, FLAG_LEVELS}, {4'h0, ~4'(i)});
			pulse(1'b1, n);
			check(Q, EXP_Q[i]);
			check(IO_SELECT_LINES, EXP_IO[i]);
			check(READ_LEVEL_N, EXP_RD[i]);
			pulse(1'b0, n);
			check(wr_count - w, {7'h0, EXP_WR[i]});
		end
		pulse(1'b0, n);
		check(code(), C_EXEC);
		DMA_IN_REQ_N = 1'b0;
		DMA_OUT_REQ_N = 1'b0;
		// interrupt held through both transfers, it is not latched
		IRQ_REQ_N = 1'b0;
		pulse(1'b0, n);
		check(code(), C_DMA);
		DMA_IN_REQ_N = 1'b1;
		pulse(1'b1, n);
		a = mem_addr;
		pulse(1'b0, n);
		check(code(), C_DMA);
		DMA_OUT_REQ_N = 1'b1;
		pulse(1'b1, n);
		check(mem_addr[7:0], a[7:0] + 8'h01);
		pulse(1'b0, n);
		check(code(), C_IACK);
		IRQ_REQ_N = 1'b1;
		pulse(1'b0, n);
		check(code(), C_FETCH);
		check(MASTER_IRQ_ENABLE, 1'b0);
		check(TEMP_SAVE, 8'h00);
		TOGGLE_Q_ENABLE_CMD = 1'b1;
		@(negedge CLK);
		TOGGLE_Q_ENABLE_CMD = 1'b0;
		for (i = 0; i < 2; i++) begin
			q0 = Q;
			dec_at(8'h02 - 8'(i));
			check(Q, q0 ^ (i == 1));
		end
		WAIT_N = 1'b0;
		repeat (12) @(negedge CLK);
		check(PAUSED, 1'b1);
		pulse(1'b0, n);
		check(8'(n), 8'h40);
		WAIT_N = 1'b1;
		pulse(1'b0, n);
		check(n < 12, 1'b1);
		CLEAR_N = 1'b0;
		repeat (20) @(negedge CLK);
		check(Q, 1'b0);
		check(MASTER_IRQ_ENABLE, 1'b1);
		CLEAR_N = 1'b1;
		pulse(1'b0, n);
		check(code(), C_FETCH);
		check(MUX_ADDRESS_LINES, 8'h00);
		dec_at(8'h01);
		check(Q, 1'b0);
		final_report();
	end
endmodule : mcs_sequencer_tb
`default_nettype wire

// *** mcs_sync.sv ***
// two-flop synchroniser bank for asynchronous pin inputs.
// assumes nothing reads the first stage.
`default_nettype none
module mcs_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : mcs_sync
`default_nettype wire
